//--- hw/sam_pkg.sv
// Shared constants for the SDRAM address map and queueing front end
package sam_pkg;
  localparam int unsigned SAM_ADDR_W = 32;
  localparam int unsigned SAM_DATA_W = 32;
  // Buffer depths in entries
  localparam int unsigned SAM_CMD_DEPTH = 7;
  localparam int unsigned SAM_WDATA_DEPTH = 11;
  localparam int unsigned SAM_RDATA_DEPTH = 15;
  // Output field widths
  localparam int unsigned SAM_BANK_W = 2;
  localparam int unsigned SAM_ROW_W = 13;
  localparam int unsigned SAM_COL_W = 11;
  localparam int unsigned SAM_DQM_W = 4;
  // Field width bases and selector limits
  localparam logic [4:0] SAM_COL_BASE_W = 5'h08;
  localparam logic [4:0] SAM_ROW_BASE_W = 5'h09;
  localparam logic [2:0] SAM_COL_SEL_MAX = 3'h3;
  localparam logic [2:0] SAM_ROW_SEL_MAX = 3'h4;
  localparam logic [2:0] SAM_BANK_SEL_MAX = 3'h2;
  localparam logic [5:0] SAM_LANE_W_WIDE = 6'h02;
  localparam logic [5:0] SAM_LANE_W_NARROW = 6'h01;
  // Burst lengths
  localparam logic [3:0] SAM_BURST_WIDE = 4'h4;
  localparam logic [3:0] SAM_BURST_NARROW = 4'h8;
  localparam logic [3:0] SAM_BURST_RST = 4'h4;
  // Access size encoding
  localparam logic [1:0] SAM_SIZE_BYTE = 2'h0;
  localparam logic [1:0] SAM_SIZE_HALF = 2'h1;
  localparam logic [1:0] SAM_SIZE_WORD = 2'h2;
  // Command buffer entry layout
  localparam int unsigned SAM_CMD_W = 32;
  localparam int unsigned SAM_CMD_DQM_LSB = 0;
  localparam int unsigned SAM_CMD_COL_LSB = 4;
  localparam int unsigned SAM_CMD_ROW_LSB = 15;
  localparam int unsigned SAM_CMD_BANK_LSB = 28;
  localparam int unsigned SAM_CMD_WRITE_BIT = 30;
  localparam int unsigned SAM_CMD_REG_BIT = 31;
endpackage

//--- hw/sam_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sam_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 7
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_push_valid,
  output logic o_push_ready,
  input wire logic [WIDTH-1:0] i_push_data,
  output logic o_pop_valid,
  input wire logic i_pop_ready,
  output logic [WIDTH-1:0] o_pop_data
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic push;
  logic pop;

  assign o_push_ready = (count_r != CNT_FULL);
  assign o_pop_valid = (count_r != '0);
  assign o_pop_data = mem_r[rd_ptr_r];
  assign push = i_push_valid && o_push_ready;
  assign pop = o_pop_valid && i_pop_ready;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      logic [WIDTH-1:0] entry_nxt;
      always_comb begin
        entry_nxt = mem_r[gi];
        if (push && (wr_ptr_r == PTR_W'(gi))) begin
          entry_nxt = i_push_data;
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          mem_r[gi] <= '0;
        end else begin
          mem_r[gi] <= entry_nxt;
        end
      end
    end
  endgenerate

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule

//--- hw/sam_addr_map_fifos.sv
// Address translation and command/data queueing front end of the SDRAM controller
`timescale 1ns/1ps
module sam_addr_map_fifos
  import sam_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_narrow_bus_sel,
  input wire logic [2:0] i_bank_count_sel,
  input wire logic [2:0] i_column_width_sel,
  input wire logic [2:0] i_row_width_sel,
  input wire logic i_bank_position_sel,
  output logic [3:0] o_burst_len,
  // Requests from the on-chip bus
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [SAM_ADDR_W-1:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_size,
  input wire logic i_req_is_reg,
  // Write data from the on-chip bus
  input wire logic i_wdata_valid,
  output logic o_wdata_ready,
  input wire logic [SAM_DATA_W-1:0] i_wdata,
  // Translated commands toward the command scheduler
  output logic o_cmd_valid,
  input wire logic i_cmd_ready,
  output logic o_cmd_is_reg,
  output logic o_cmd_write,
  output logic [SAM_BANK_W-1:0] o_cmd_bank,
  output logic [SAM_ROW_W-1:0] o_cmd_row,
  output logic [SAM_COL_W-1:0] o_cmd_col,
  output logic [SAM_DQM_W-1:0] o_cmd_dqm,
  // Write data toward the data scheduler
  output logic o_mem_wdata_valid,
  input wire logic i_mem_wdata_ready,
  output logic [SAM_DATA_W-1:0] o_mem_wdata,
  // Read data returning from memory
  input wire logic i_mem_rdata_valid,
  output logic o_mem_rdata_ready,
  input wire logic [SAM_DATA_W-1:0] i_mem_rdata,
  // Read data toward the on-chip bus
  output logic o_rdata_valid,
  input wire logic i_rdata_ready,
  output logic [SAM_DATA_W-1:0] o_rdata
);

  // Extract a field of given width starting at a given bit
  function automatic logic [31:0] sam_field(
    input logic [31:0] addr,
    input logic [5:0] shift,
    input logic [4:0] width
  );
    logic [31:0] mask;
    begin
      mask = (32'h0000_0001 << width) - 32'h0000_0001;
      sam_field = (addr >> shift) & mask;
    end
  endfunction

  // Limit a selector to its largest legal value
  function automatic logic [2:0] sam_clamp(input logic [2:0] sel, input logic [2:0] lim);
    begin
      sam_clamp = (sel > lim) ? lim : sel;
    end
  endfunction

  // Offset of the field that sits directly above another
  function automatic logic [5:0] sam_above(input logic [5:0] shift, input logic [4:0] width);
    begin
      sam_above = shift + {1'h0, width};
    end
  endfunction

  // Whether one byte lane takes part in an access
  function automatic logic sam_lane_hit(
    input logic [1:0] lane,
    input logic narrow,
    input logic [1:0] size,
    input logic [1:0] addr_lsb
  );
    logic hit;
    begin
      hit = 1'h0;
      if (narrow) begin
        // Upper lanes never carry data on the narrow bus
        if (lane[1]) begin
          hit = 1'h0;
        end else if (size == SAM_SIZE_BYTE) begin
          hit = (lane[0] == addr_lsb[0]);
        end else begin
          hit = 1'h1;
        end
      end else begin
        case (size)
          SAM_SIZE_BYTE: hit = (lane == addr_lsb);
          SAM_SIZE_HALF: hit = (lane[1] == addr_lsb[1]);
          default: hit = 1'h1;
        endcase
      end
      sam_lane_hit = hit;
    end
  endfunction

  logic [3:0] burst_r, burst_nxt;
  logic [5:0] lane_w;
  logic [4:0] col_w;
  logic [4:0] row_w;
  logic [4:0] bank_w;
  logic [5:0] col_sh;
  logic [5:0] row_sh;
  logic [5:0] bank_sh;
  logic [SAM_COL_W-1:0] map_col;
  logic [SAM_ROW_W-1:0] map_row;
  logic [SAM_BANK_W-1:0] map_bank;
  logic [SAM_DQM_W-1:0] lane_en;
  logic [SAM_DQM_W-1:0] map_dqm;
  logic [SAM_CMD_W-1:0] cmd_entry;
  logic [SAM_CMD_W-1:0] cmd_head;
  logic cmd_push_ready;
  logic cmd_push;
  logic wdata_push_ready;
  logic [2:0] col_sel;
  logic [2:0] row_sel;
  logic [2:0] bank_sel;
  logic [5:0] map_top;
  logic [SAM_ADDR_W-1:0] addr_kept;

  // Out-of-range selectors act as the largest legal value
  always_comb begin
    col_sel = sam_clamp(i_column_width_sel, SAM_COL_SEL_MAX);
    row_sel = sam_clamp(i_row_width_sel, SAM_ROW_SEL_MAX);
    bank_sel = sam_clamp(i_bank_count_sel, SAM_BANK_SEL_MAX);
  end

  // Field widths from the configuration
  always_comb begin
    lane_w = i_narrow_bus_sel ? SAM_LANE_W_NARROW : SAM_LANE_W_WIDE;
    col_w = SAM_COL_BASE_W + {2'h0, col_sel};
    // row width; thirteenth bit only at largest size
    row_w = SAM_ROW_BASE_W + {2'h0, row_sel};
    bank_w = {2'h0, bank_sel};
    col_sh = lane_w;
    if (i_bank_position_sel) begin
      // mobile order: bank above row above column
      row_sh = sam_above(col_sh, col_w);
      bank_sh = sam_above(row_sh, row_w);
      map_top = sam_above(bank_sh, bank_w);
    end else begin
      // standard order: row above bank above column
      bank_sh = sam_above(col_sh, col_w);
      row_sh = sam_above(bank_sh, bank_w);
      map_top = sam_above(row_sh, row_w);
    end
  end

  // bits above the top field read as zero
  genvar gb;
  generate
    for (gb = 0; gb < SAM_ADDR_W; gb++) begin : g_addr_bit
      assign addr_kept[gb] = i_req_addr[gb] && (6'(gb) < map_top);
    end
  endgenerate

  // Address fields; bits above the top field are masked off
  always_comb begin
    map_col = SAM_COL_W'(sam_field(addr_kept, col_sh, col_w));
    map_row = SAM_ROW_W'(sam_field(addr_kept, row_sh, row_w));
    map_bank = SAM_BANK_W'(sam_field(addr_kept, bank_sh, bank_w));
  end

  genvar gl;
  generate
    for (gl = 0; gl < SAM_DQM_W; gl++) begin : g_lane
      assign lane_en[gl] = sam_lane_hit(2'(gl), i_narrow_bus_sel, i_req_size, i_req_addr[1:0]);
    end
  endgenerate

  // masks disable unwanted bytes on writes only
  always_comb begin
    map_dqm = (i_req_write && !i_req_is_reg) ? ~lane_en : '0;
  end

  // Translated once on entry; later config changes leave queued entries
  // Packed command entry
  always_comb begin
    cmd_entry = '0;
    cmd_entry[SAM_CMD_REG_BIT] = i_req_is_reg;
    cmd_entry[SAM_CMD_WRITE_BIT] = i_req_write;
    cmd_entry[SAM_CMD_DQM_LSB +: SAM_DQM_W] = map_dqm;
    // register accesses share the path untranslated
    if (!i_req_is_reg) begin
      cmd_entry[SAM_CMD_COL_LSB +: SAM_COL_W] = map_col;
      cmd_entry[SAM_CMD_ROW_LSB +: SAM_ROW_W] = map_row;
      cmd_entry[SAM_CMD_BANK_LSB +: SAM_BANK_W] = map_bank;
    end
  end

  // Full-based ready; a same-cycle pop frees no slot
  // stall while either inbound buffer is full
  assign o_req_ready = cmd_push_ready && wdata_push_ready;
  assign cmd_push = i_req_valid && o_req_ready;

  sam_fifo #(
    .WIDTH(SAM_CMD_W),
    .DEPTH(SAM_CMD_DEPTH)
  ) u_cmd_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push_valid(cmd_push),
    .o_push_ready(cmd_push_ready),
    .i_push_data(cmd_entry),
    .o_pop_valid(o_cmd_valid),
    .i_pop_ready(i_cmd_ready),
    .o_pop_data(cmd_head)
  );

  // Head entry fields straight from the buffer flops
  assign o_cmd_is_reg = cmd_head[SAM_CMD_REG_BIT];
  assign o_cmd_write = cmd_head[SAM_CMD_WRITE_BIT];
  assign o_cmd_bank = cmd_head[SAM_CMD_BANK_LSB +: SAM_BANK_W];
  assign o_cmd_row = cmd_head[SAM_CMD_ROW_LSB +: SAM_ROW_W];
  assign o_cmd_col = cmd_head[SAM_CMD_COL_LSB +: SAM_COL_W];
  assign o_cmd_dqm = cmd_head[SAM_CMD_DQM_LSB +: SAM_DQM_W];

  assign o_wdata_ready = wdata_push_ready;

  sam_fifo #(
    .WIDTH(SAM_DATA_W),
    .DEPTH(SAM_WDATA_DEPTH)
  ) u_wdata_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push_valid(i_wdata_valid),
    .o_push_ready(wdata_push_ready),
    .i_push_data(i_wdata),
    .o_pop_valid(o_mem_wdata_valid),
    .i_pop_ready(i_mem_wdata_ready),
    .o_pop_data(o_mem_wdata)
  );

  sam_fifo #(
    .WIDTH(SAM_DATA_W),
    .DEPTH(SAM_RDATA_DEPTH)
  ) u_rdata_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push_valid(i_mem_rdata_valid),
    .o_push_ready(o_mem_rdata_ready),
    .i_push_data(i_mem_rdata),
    .o_pop_valid(o_rdata_valid),
    .i_pop_ready(i_rdata_ready),
    .o_pop_data(o_rdata)
  );

  always_comb begin
    burst_nxt = i_narrow_bus_sel ? SAM_BURST_NARROW : SAM_BURST_WIDE;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      burst_r <= SAM_BURST_RST;
    end else begin
      burst_r <= burst_nxt;
    end
  end

  assign o_burst_len = burst_r;
endmodule

//--- dv/sam_checker.sv
// Port checker for the SDRAM address map front end
`timescale 1ns/1ps
module sam_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_narrow_bus_sel,
  input wire logic [3:0] o_burst_len,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic i_wdata_valid,
  input wire logic o_wdata_ready,
  input wire logic o_cmd_valid,
  input wire logic i_cmd_ready,
  input wire logic o_cmd_write,
  input wire logic [10:0] o_cmd_col,
  input wire logic [3:0] o_cmd_dqm,
  input wire logic o_mem_wdata_valid,
  input wire logic i_mem_rdata_valid,
  input wire logic o_mem_rdata_ready,
  input wire logic o_rdata_valid,
  input wire logic i_rdata_ready
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_burst_len: assert property (!$past(i_rst) |-> o_burst_len == ($past(i_narrow_bus_sel) ? 4'h8 : 4'h4))
    else $error("burst length wrong");
  a_cmd_push: assert property (i_req_valid && o_req_ready |=> o_cmd_valid)
    else $error("command lost");
  a_wdata_push: assert property (i_wdata_valid && o_wdata_ready |=> o_mem_wdata_valid)
    else $error("write word lost");
  a_rdata_push: assert property (i_mem_rdata_valid && o_mem_rdata_ready |=> o_rdata_valid)
    else $error("read word lost");
  a_read_unmasked: assert property (o_cmd_valid && !o_cmd_write |-> o_cmd_dqm == 4'h0)
    else $error("read mask not low");
  a_head_hold: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd_col))
    else $error("command head moved");
  a_no_stall: assert property (!o_cmd_valid && !o_mem_wdata_valid |-> o_req_ready)
    else $error("stall while empty");
  a_rdata_hold: assert property (o_rdata_valid && !i_rdata_ready |=> o_rdata_valid)
    else $error("read head dropped");
  c_req_stall: cover property (!o_req_ready);
  c_write_wait: cover property (o_cmd_valid && o_cmd_write && !i_cmd_ready);
  c_read_wait: cover property (o_rdata_valid && !i_rdata_ready);
endmodule

bind sam_addr_map_fifos sam_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_narrow_bus_sel(i_narrow_bus_sel), .o_burst_len(o_burst_len), .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready), .i_wdata_valid(i_wdata_valid), .o_wdata_ready(o_wdata_ready),
  .o_cmd_valid(o_cmd_valid), .i_cmd_ready(i_cmd_ready), .o_cmd_write(o_cmd_write), .o_cmd_col(o_cmd_col),
  .o_cmd_dqm(o_cmd_dqm), .o_mem_wdata_valid(o_mem_wdata_valid), .i_mem_rdata_valid(i_mem_rdata_valid),
  .o_mem_rdata_ready(o_mem_rdata_ready), .o_rdata_valid(o_rdata_valid), .i_rdata_ready(i_rdata_ready));

//--- dv/sam_partner.sv
// Scheduler and memory side model for the SDRAM front end
`timescale 1ns/1ps
module sam_partner (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hold,
  input wire logic i_slow,
  input wire logic i_rd_go,
  input wire logic [4:0] i_rd_n,
  output logic o_cmd_ready,
  output logic o_wdata_ready,
  output logic o_rdata_valid,
  input wire logic i_rdata_ready,
  output logic [31:0] o_rdata
);
  logic [4:0] left_r;
  logic [7:0] idx_r;
  logic tick_r;
  // Slow mode takes on every other cycle only
  assign o_cmd_ready = !i_hold && (tick_r || !i_slow);
  assign o_wdata_ready = o_cmd_ready;
  assign o_rdata_valid = left_r != 5'h00;
  // Idle data is the inverse of the pending word
  assign o_rdata = o_rdata_valid ? {24'hC0_DE00, idx_r} : ~{24'hC0_DE00, idx_r};
  always_ff @(posedge i_sys_clk) begin
    tick_r <= !i_rst && !tick_r;
    if (i_rst) begin
      {left_r, idx_r} <= 13'h0000;
    end else if (i_rd_go) begin
      left_r <= i_rd_n;
    end else if (o_rdata_valid && i_rdata_ready) begin
      left_r <= left_r - 5'h01;
      idx_r <= idx_r + 8'h01;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the SDRAM address map front end
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_narrow_bus_sel = 1'h0, i_bank_position_sel = 1'h0, i_req_valid = 1'h0;
  logic i_req_write = 1'h0, i_req_is_reg = 1'h0, i_wdata_valid = 1'h0, i_rdata_ready = 1'h0;
  logic hold = 1'h0, slow = 1'h0, rd_go = 1'h0;
  logic [2:0] i_bank_count_sel = 3'h0, i_column_width_sel = 3'h0, i_row_width_sel = 3'h0;
  logic [1:0] i_req_size = 2'h0, o_cmd_bank;
  logic [4:0] rd_n = 5'h00;
  logic [31:0] i_req_addr = 32'h0000_0000, i_wdata = 32'h0000_0000, r = 32'h0000_0030;
  logic o_req_ready, o_wdata_ready, o_cmd_valid, i_cmd_ready, o_cmd_is_reg, o_cmd_write, o_mem_wdata_valid;
  logic i_mem_wdata_ready, i_mem_rdata_valid, o_mem_rdata_ready, o_rdata_valid;
  logic [3:0] o_burst_len, o_cmd_dqm;
  logic [12:0] o_cmd_row;
  logic [10:0] o_cmd_col;
  logic [31:0] o_mem_wdata, i_mem_rdata, o_rdata;
  logic [31:0] qc[$], qw[$], qr[$];
  int n_errors = 0, samples_checked = 0;

  sam_addr_map_fifos dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_narrow_bus_sel(i_narrow_bus_sel),
    .i_bank_count_sel(i_bank_count_sel), .i_column_width_sel(i_column_width_sel),
    .i_row_width_sel(i_row_width_sel), .i_bank_position_sel(i_bank_position_sel), .o_burst_len(o_burst_len),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_addr(i_req_addr), .i_req_write(i_req_write),
    .i_req_size(i_req_size), .i_req_is_reg(i_req_is_reg), .i_wdata_valid(i_wdata_valid),
    .o_wdata_ready(o_wdata_ready), .i_wdata(i_wdata), .o_cmd_valid(o_cmd_valid), .i_cmd_ready(i_cmd_ready),
    .o_cmd_is_reg(o_cmd_is_reg), .o_cmd_write(o_cmd_write), .o_cmd_bank(o_cmd_bank), .o_cmd_row(o_cmd_row),
    .o_cmd_col(o_cmd_col), .o_cmd_dqm(o_cmd_dqm), .o_mem_wdata_valid(o_mem_wdata_valid),
    .i_mem_wdata_ready(i_mem_wdata_ready), .o_mem_wdata(o_mem_wdata), .i_mem_rdata_valid(i_mem_rdata_valid),
    .o_mem_rdata_ready(o_mem_rdata_ready), .i_mem_rdata(i_mem_rdata), .o_rdata_valid(o_rdata_valid),
    .i_rdata_ready(i_rdata_ready), .o_rdata(o_rdata));
  sam_partner u_far (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hold(hold), .i_slow(slow), .i_rd_go(rd_go),
    .i_rd_n(rd_n), .o_cmd_ready(i_cmd_ready), .o_wdata_ready(i_mem_wdata_ready),
    .o_rdata_valid(i_mem_rdata_valid), .i_rdata_ready(o_mem_rdata_ready), .o_rdata(i_mem_rdata));

  always #5 i_sys_clk = ~i_sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() ? q.pop_front() : 32'hxxxx_xxxx;
  endfunction

  function automatic logic [31:0] xlate(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic rg);
    int lw, cw, rw, bw;
    logic [31:0] s, row, bank;
    logic [3:0] en;
    lw = i_narrow_bus_sel ? 1 : 2;
    cw = 8 + (i_column_width_sel > 3 ? 3 : i_column_width_sel);
    rw = 9 + (i_row_width_sel > 4 ? 4 : i_row_width_sel);
    bw = i_bank_count_sel > 2 ? 2 : i_bank_count_sel;
    s = a >> (lw + cw);
    // Bank above row when mobile, below it otherwise
    row = (i_bank_position_sel ? s : s >> bw) & ((32'h1 << rw) - 1);
    bank = (i_bank_position_sel ? s >> rw : s) & ((32'h1 << bw) - 1);
    if (sz == 2'h0)
      en = 4'h1 << (i_narrow_bus_sel ? 2'(a[0]) : a[1:0]);
    else
      en = (sz == 2'h1 && !i_narrow_bus_sel && a[1]) ? 4'hC : (sz == 2'h1 || i_narrow_bus_sel ? 4'h3 : 4'hF);
    if (rg)
      return {1'h1, wr, 30'h0000_0000};
    return {1'h0, wr, bank[1:0], row[12:0], 11'((a >> lw) & ((32'h1 << cw) - 1)), wr ? ~en : 4'h0};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic req(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic rg);
    @(posedge i_sys_clk);
    {i_req_valid, i_req_addr, i_req_size, i_req_write, i_req_is_reg} <= {1'h1, a, sz, wr, rg};
    qc.push_back(xlate(a, sz, wr, rg));
    do @(posedge i_sys_clk); while (o_req_ready !== 1'h1);
    i_req_valid <= 1'h0;
  endtask

  task automatic wpush(input logic [31:0] d);
    @(posedge i_sys_clk);
    {i_wdata_valid, i_wdata} <= {1'h1, d};
    qw.push_back(d);
    do @(posedge i_sys_clk); while (o_wdata_ready !== 1'h1);
    i_wdata_valid <= 1'h0;
  endtask

  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    if (o_cmd_valid && i_cmd_ready)
      chk({o_cmd_is_reg, o_cmd_write, o_cmd_bank, o_cmd_row, o_cmd_col, o_cmd_dqm}, pop(qc));
    if (o_mem_wdata_valid && i_mem_wdata_ready)
      chk(o_mem_wdata, pop(qw));
    if (o_rdata_valid && i_rdata_ready)
      chk(o_rdata, pop(qr));
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    // Empty buffers, open readies and wide bursts after reset
    @(posedge i_sys_clk);
    chk(32'({o_cmd_valid, o_mem_wdata_valid, o_rdata_valid, o_burst_len}), 32'h0000_0004);
    chk(32'({o_req_ready, o_wdata_ready, o_mem_rdata_ready}), 32'h0000_0007);
    for (int k = 0; k < 320; k++) begin
      @(posedge i_sys_clk);
      {i_bank_position_sel, i_narrow_bus_sel} <= 2'(k / 80);
      // Out-of-range selectors appear too, so the clamping is exercised
      {i_bank_count_sel, i_column_width_sel, i_row_width_sel} <= {3'(k / 20 % 4),
        3'(k / 5 % 4 == 3 && k % 2 ? 7 : k / 5 % 4), 3'(k % 5 == 4 && k / 5 % 2 ? 7 : k % 5)};
      repeat (3) begin
        repeat (5) r = lfsr(r);
        slow <= r[7];
        req(r, 2'(r[5:4] % 3), r[6], k % 8 == 0);
      end
    end
    // Seven commands fill the buffer with the scheduler held off
    wait (qc.size() == 0);
    hold <= 1'h1;
    repeat (7) req(32'h0000_0104, 2'h2, 1'h1, 1'h0);
    @(posedge i_sys_clk);
    chk(32'(o_req_ready), 32'h0000_0000);
    hold <= 1'h0;
    wait (qc.size() == 0);
    hold <= 1'h1;
    for (int j = 0; j < 11; j++) wpush(32'hDA7A_0000 + 32'(j));
    @(posedge i_sys_clk);
    chk(32'({o_wdata_ready, o_req_ready}), 32'h0000_0000);
    hold <= 1'h0;
    rd_n <= 5'h10;
    rd_go <= 1'h1;
    for (int j = 0; j < 16; j++) qr.push_back({24'hC0_DE00, 8'(j)});
    @(posedge i_sys_clk);
    rd_go <= 1'h0;
    repeat (20) @(posedge i_sys_clk);
    chk(32'(o_mem_rdata_ready), 32'h0000_0000);
    repeat (60) begin
      @(posedge i_sys_clk);
      r = lfsr(r);
      i_rdata_ready <= r[0];
    end
    chk(32'(qr.size() + qw.size()), 32'h0000_0000);
    test_done();
  end

  initial begin
    #400_000;
    n_errors++;
    test_done();
  end
endmodule
